//--- src/uhcs_regs.sv
// Command/status and interrupt event flag register bank
// Functional notes
// - Two-bit overrun counter at bits 17:16
// - Counter resets to zero and wraps
// - Counter counts even when flag set
// - Reset request starts software reset, suspended state
// - Hardware clears request; done within 10 us
// - Software reset spares root hub, ports
// - Events set flags; only write-one or software reset clears
// - Write one clears flag; zero ignored
// - Interrupt needs flag, enable and master gate
// - Root hub change flag at bit 6
// - Frame number wrap flag at bit 5
// - Unrecoverable error flag at bit 4, no halt logic
// - Unrecoverable error flag kept cleared here
// - Resume flag only on downstream resume
// - Frame start flag at bit 2
// - Overrun sets bit 0 and counts
// - Event flags read 03h, written 83h
// - Command register writes are write-to-set
// - Command register read 02h, written 82h
// - Overrun when periodic list misses frame end
`timescale 1ns/100ps
`include "uhcs_params.svh"
module uhcs_regs
	import uhcs_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [31:0] wr_data,
	output logic      [31:0] rd_data,
	input  wire logic        root_hub_change,
	input  wire logic        frame_msb,
	input  wire logic        resume_signal,
	input  wire logic        frame_start,
	input  wire logic        periodic_busy_at_eof,
	input  wire logic        frame_end,
	input  wire logic        sw_resume_entry,
	output logic             sof_token,
	output logic             enter_suspended_state,
	output logic             op_regs_reset,
	output logic             sw_reset_busy,
	output logic             irq_request
);
	localparam int SWRST_CYC = `UHCS_SWRST_USED < `UHCS_SWRST_CYCLES ? `UHCS_SWRST_USED : `UHCS_SWRST_CYCLES;

	typedef struct packed {
		uhcs_rst_state_t st;
		logic [8:0]      cnt;
		logic            swrst;
		logic [1:0]      ovc;
		logic [31:0]     flags;
		logic [31:0]     enables;
		logic            msb_prev;
		logic            res_prev;
		logic            sof;
	} uhcs_state_t;

	uhcs_state_t s_q;
	uhcs_state_t s_d;
	logic        rd_load;
	logic [31:0] rd_value;
	logic [31:0] ev;

	// Decode a command byte against a code
	function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] want);
		is_cmd = code == want;
	endfunction

	// Event vector, write-one-to-clear flags, overrun counter, reset sequence
	always_comb begin
		s_d = s_q;
		ev = 32'h0;
		ev[`UHCS_BIT_ROOT_HUB_CHANGE_FLAG] = root_hub_change;
		ev[`UHCS_BIT_FNO] = frame_msb != s_q.msb_prev;
		ev[`UHCS_BIT_UE] = 1'b0;
		ev[`UHCS_BIT_RD] = resume_signal && !s_q.res_prev && !sw_resume_entry;
		ev[`UHCS_BIT_SF] = frame_start;
		ev[`UHCS_BIT_SO] = frame_end && periodic_busy_at_eof;
		s_d.msb_prev = frame_msb;
		s_d.res_prev = resume_signal;
		s_d.sof = frame_start;
		if (cmd_valid && is_cmd(cmd_code, `UHCS_CMD_EVFLAG_WR)) begin
			s_d.flags = s_q.flags & ~(wr_data & `UHCS_FLAG_MASK);
		end
		if (cmd_valid && is_cmd(cmd_code, `UHCS_CMD_EVEN_WR)) begin
			s_d.enables = s_q.enables | (wr_data & (`UHCS_FLAG_MASK | 32'h80000000));
		end
		if (cmd_valid && is_cmd(cmd_code, `UHCS_CMD_EVDIS_WR)) begin
			s_d.enables = s_q.enables & ~wr_data;
		end
		s_d.flags = (s_d.flags | ev) & `UHCS_FLAG_MASK;
		if (ev[`UHCS_BIT_SO]) begin
			s_d.ovc = s_q.ovc + 2'b01;
		end
		if (cmd_valid && is_cmd(cmd_code, `UHCS_CMD_CMDSTAT_WR) && wr_data[`UHCS_BIT_SWRST]) begin
			s_d.swrst = 1'b1;
		end
		unique case (s_q.st)
			UHCS_IDLE: begin
				if (s_d.swrst) begin
					s_d.st = UHCS_RESET;
					s_d.cnt = 9'd0;
				end
			end
			UHCS_RESET: begin
				s_d.flags = 32'h0;
				s_d.enables = 32'h0;
				s_d.ovc = 2'b00;
				s_d.cnt = s_q.cnt + 9'd1;
				if (s_q.cnt == 9'(SWRST_CYC - 1)) begin
					s_d.st = UHCS_DONE;
				end
			end
			UHCS_DONE: begin
				s_d.swrst = 1'b0;
				s_d.st = UHCS_IDLE;
			end
			default: begin
				s_d.st = UHCS_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Read selection by command code
	always_comb begin
		rd_load = cmd_valid;
		rd_value = 32'h0;
		if (is_cmd(cmd_code, `UHCS_CMD_CMDSTAT_RD)) begin
			rd_value = {14'h0, s_q.ovc, 15'h0, s_q.swrst};
		end else if (is_cmd(cmd_code, `UHCS_CMD_EVFLAG_RD)) begin
			rd_value = s_q.flags;
		end else if (is_cmd(cmd_code, `UHCS_CMD_EVEN_RD) || is_cmd(cmd_code, `UHCS_CMD_EVDIS_RD)) begin
			rd_value = s_q.enables;
		end
	end

	uhcs_rdreg u_rd (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.load    (rd_load),
		.value   (rd_value),
		.rd_data (rd_data)
	);

	// Outputs
	assign irq_request = s_q.enables[`UHCS_BIT_MIE] && |(s_q.flags & s_q.enables & `UHCS_FLAG_MASK);
	assign sof_token = s_q.sof;
	assign sw_reset_busy = s_q.st != UHCS_IDLE;
	assign enter_suspended_state = s_q.st == UHCS_RESET;
	assign op_regs_reset = s_q.st == UHCS_RESET;
endmodule

//--- inc/uhcs_params.svh
// Constants for the host command/status and interrupt event flag registers
`ifndef UHCS_PARAMS_SVH
`define UHCS_PARAMS_SVH
`define UHCS_CMD_CMDSTAT_RD   8'h02
`define UHCS_CMD_CMDSTAT_WR   8'h82
`define UHCS_CMD_EVFLAG_RD    8'h03
`define UHCS_CMD_EVFLAG_WR    8'h83
`define UHCS_CMD_EVEN_RD      8'h04
`define UHCS_CMD_EVEN_WR      8'h84
`define UHCS_CMD_EVDIS_RD     8'h05
`define UHCS_CMD_EVDIS_WR     8'h85
`define UHCS_BIT_SWRST        0
`define UHCS_BIT_OVC_LO       16
`define UHCS_BIT_OVC_HI       17
`define UHCS_BIT_SO           0
`define UHCS_BIT_SF           2
`define UHCS_BIT_RD           3
`define UHCS_BIT_UE           4
`define UHCS_BIT_FNO          5
`define UHCS_BIT_ROOT_HUB_CHANGE_FLAG         6
`define UHCS_BIT_MIE          31
`define UHCS_FLAG_MASK        32'h0000007d
`define UHCS_RESET_VALUE      32'h00000000
`define UHCS_SWRST_TIME_NS    10000
`define UHCS_CLK_PERIOD_NS    25
`define UHCS_SWRST_CYCLES     (`UHCS_SWRST_TIME_NS / `UHCS_CLK_PERIOD_NS)
`define UHCS_SWRST_USED       16
`endif

//--- inc/uhcs_pkg.sv
// Types for the host command/status block
package uhcs_pkg;
	typedef enum logic [1:0] {
		UHCS_IDLE  = 2'b00,
		UHCS_RESET = 2'b01,
		UHCS_DONE  = 2'b10
	} uhcs_rst_state_t;
endpackage

//--- src/uhcs_rdreg.sv
// Registered read data mux for the register bank
`timescale 1ns/100ps
module uhcs_rdreg (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        load,
	input  wire logic [31:0] value,
	output logic      [31:0] rd_data
);
	// Capture read data on every valid command, read or write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 32'h0;
		end else if (load) begin
			rd_data <= value;
		end
	end
endmodule

//--- bench/uhcs_chk.sv
// Port checker for the register bank
`timescale 1ns/100ps
module uhcs_chk (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_code,
	input wire logic [31:0] wr_data,
	input wire logic [31:0] rd_data,
	input wire logic        frame_start,
	input wire logic        sof_token,
	input wire logic        enter_suspended_state,
	input wire logic        op_regs_reset,
	input wire logic        sw_reset_busy,
	input wire logic        irq_request
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Frame token, read views, reset sequencing and interrupt gating
	property p_sof; frame_start |=> sof_token; endproperty
	a_sof: assert property (p_sof) else $error("token missing");
	property p_ev; cmd_valid && cmd_code == 8'h03 |=> rd_data[31:7] == 0 && !rd_data[4] && !rd_data[1]; endproperty
	a_ev: assert property (p_ev) else $error("flag view bad");
	property p_cs; cmd_valid && cmd_code == 8'h02 && !sw_reset_busy |=> rd_data[31:18] == 0 && rd_data[15:0] == 0; endproperty
	a_cs: assert property (p_cs) else $error("command view bad");
	property p_swr; cmd_valid && cmd_code == 8'h82 && wr_data[0] |=> sw_reset_busy && enter_suspended_state; endproperty
	a_swr: assert property (p_swr) else $error("reset not started");
	property p_len; $rose(sw_reset_busy) |-> ##[1:400] !sw_reset_busy; endproperty
	a_len: assert property (p_len) else $error("reset too long");
	property p_op; op_regs_reset |-> sw_reset_busy; endproperty
	a_op: assert property (p_op) else $error("stray clear");
	property p_sus; $fell(sw_reset_busy) |-> !enter_suspended_state; endproperty
	a_sus: assert property (p_sus) else $error("suspend stuck");
	property p_irq; op_regs_reset ##1 op_regs_reset |=> !irq_request; endproperty
	a_irq: assert property (p_irq) else $error("irq during reset");
endmodule
bind uhcs_regs uhcs_chk u_uhcs_chk (.clk_sys, .rst_n, .cmd_valid, .cmd_code, .wr_data, .rd_data,
	.frame_start, .sof_token, .enter_suspended_state, .op_regs_reset, .sw_reset_busy, .irq_request);

//--- bench/uhcs_host.sv
// Host processor model issuing register commands
`timescale 1ns/100ps
module uhcs_host (
	input wire logic        clk_sys,
	input wire logic        sw_reset_busy,
	input wire logic [31:0] rd_data,
	output logic            cmd_valid = 1'b0,
	output logic     [7:0]  cmd_code = 8'h00,
	output logic     [31:0] wr_data = 32'h0
);
	// One command over one rising edge; released lines show inverted values
	task automatic xfer(input logic [7:0] c, input logic [31:0] d, output logic [31:0] q);
		@(negedge clk_sys);
		while (sw_reset_busy) @(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_code = c;
		wr_data = d;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		cmd_code = ~c;
		wr_data = ~d;
		q = rd_data;
	endtask
endmodule

//--- bench/usb_host_cmd_irq_status_bench.sv
// Self-checking bench for the command/status register bank
`timescale 1ns/100ps
module usb_host_cmd_irq_status_bench;
	logic        clk_sys, rst_n, root_hub_change, frame_msb, resume_signal, frame_start, periodic_busy_at_eof;
	logic        frame_end, sw_resume_entry, cmd_valid, sof_token, enter_suspended_state, op_regs_reset;
	logic        sw_reset_busy, irq_request;
	logic [7:0]  cmd_code;
	logic [31:0] wr_data, rd_data, q;
	logic [15:0] rnd = 16'h005b;
	int          num_errors = 0, n_checks = 0, cyc = 0;
	uhcs_regs u_uhcs_regs (.clk_sys, .rst_n, .cmd_valid, .cmd_code, .wr_data, .rd_data, .root_hub_change,
		.frame_msb, .resume_signal, .frame_start, .periodic_busy_at_eof, .frame_end, .sw_resume_entry,
		.sof_token, .enter_suspended_state, .op_regs_reset, .sw_reset_busy, .irq_request);
	uhcs_host u_uhcs_host (.clk_sys, .sw_reset_busy, .rd_data, .cmd_valid, .cmd_code, .wr_data);
	// Clock and hang limit
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (++cyc == 5000) begin
		num_errors++;
		close_out;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk_sys);
		s = 1'b1;
		@(negedge clk_sys);
		s = 1'b0;
	endtask
	task automatic wr(input logic [7:0] c, input logic [31:0] d);
		u_uhcs_host.xfer(c, d, q);
		rnd = lfsr(rnd);
	endtask
	task automatic rd(input logic [7:0] c, input logic [31:0] e);
		wr(c, {rnd, rnd});
		chk(q, e);
	endtask
	// Main sequence: overruns, event flags, clearing, interrupt gate, soft reset
	initial begin
		{rst_n, root_hub_change, frame_msb, resume_signal, frame_start, periodic_busy_at_eof} = 0;
		{frame_end, sw_resume_entry} = 0;
		repeat (5) @(negedge clk_sys);
		rst_n = 1'b1;
		rd(8'h03, 32'h0);
		rd(8'h02, 32'h0);
		frame_end = 1'b1;
		repeat (5) pulse(periodic_busy_at_eof);
		frame_end = 1'b0;
		pulse(frame_end);
		rd(8'h02, 32'h00010000);
		rd(8'h03, 32'h1);
		wr(8'h82, {rnd, rnd} & 32'hfffffffe);
		rd(8'h02, 32'h00010000);
		wr(8'h83, {rnd, rnd} & 32'hfffffffe);
		rd(8'h03, 32'h1);
		wr(8'h83, 32'h1);
		rd(8'h03, 32'h0);
		pulse(frame_start);
		pulse(root_hub_change);
		frame_msb = 1'b1;
		sw_resume_entry = 1'b1;
		pulse(resume_signal);
		sw_resume_entry = 1'b0;
		rd(8'h03, 32'h64);
		wr(8'h83, 32'h64);
		frame_msb = 1'b0;
		pulse(resume_signal);
		rd(8'h03, 32'h28);
		wr(8'h84, 32'h8);
		chk(32'(irq_request), 32'h0);
		wr(8'h84, 32'h80000000);
		chk(32'(irq_request), 32'h1);
		wr(8'h83, 32'h28);
		chk(32'(irq_request), 32'h0);
		wr(8'h85, 32'h8);
		rd(8'h05, 32'h80000000);
		wr(8'h82, 32'h1);
		rd(8'h02, 32'h0);
		rd(8'h04, 32'h0);
		wr(8'h83, 32'h10);
		rd(8'h03, 32'h0);
		close_out;
	end
endmodule
